/* File: rtl/flash_rewrite_ctrl.sv */
// CPU-driven flash rewrite controller with suspend and AHB-Lite registers
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module flash_rewrite_ctrl (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // Flash array core
    output flash_rewrite_pkg::core_req_s     core_req,
    input  wire flash_rewrite_pkg::core_rsp_s core_rsp,
    // CPU and interrupt side
    input  wire logic                        irq_request,
    output logic                             cpu_hold,
    output logic                             irq_ack_allow,
    output logic                             flash_read_allow
);
    import flash_rewrite_pkg::*;

    op_state_e   state_ff,        nxt_state;
    logic [11:0] lat_cnt_ff,      nxt_lat_cnt;
    logic        cpu_en_ff,       nxt_cpu_en;
    logic        low_en_ff,       nxt_low_en;
    logic        submode_ff,      nxt_submode;
    logic        lock0_ff,        nxt_lock0;
    logic        lock1_ff,        nxt_lock1;
    logic        susp_en_ff,      nxt_susp_en;
    logic        ers_req_ff,      nxt_ers_req;
    logic        prg_req_ff,      nxt_prg_req;
    logic        is_erase_ff,     nxt_is_erase;
    logic [3:0]  block_ff,        nxt_block;
    logic        prog_err_ff,     nxt_prog_err;
    logic        erase_err_ff,    nxt_erase_err;
    logic        stat_mode_ff,    nxt_stat_mode;
    logic        wr_pend_ff,      nxt_wr_pend;
    logic [8:0]  wr_idx_ff,       nxt_wr_idx;
    logic [31:0] hrdata_ff,       nxt_hrdata;
    logic        cpu_hold_ff,     nxt_cpu_hold;
    logic        irq_allow_ff,    nxt_irq_allow;
    logic        rd_allow_ff,     nxt_rd_allow;
    core_req_s   core_req_ff,     nxt_core_req;
    logic        ready_ff,        nxt_ready;
    logic        resp_ff,         nxt_resp;

    logic        addr_phase;
    logic [8:0]  addr_idx;
    logic        busy;
    logic        start_ok;
    logic        blk_ok;
    logic [3:0]  cmd_block;
    logic        susp_pending;
    logic        finish;

    assign addr_phase = hsel && htrans[1] && hready;
    assign addr_idx   = haddr[10:2];
    assign busy       = (state_ff != ST_IDLE);
    assign cmd_block  = hwdata[B_CMD_BLK_LO +: 4];

    // Blocks 0 and 1 are guarded by the low-block enable and their own lock
    always_comb begin
        if (cmd_block == 4'h0) begin
            blk_ok = low_en_ff && !lock0_ff;
        end else if (cmd_block == 4'h1) begin
            blk_ok = low_en_ff && !lock1_ff;
        end else begin
            blk_ok = 1'b1;
        end
    end

    // Bus side: read mux, sampled in the address phase so data stands in the data phase
    // Limitation: a read issued in a write's data phase returns the value before that write
    always_comb begin
        nxt_wr_pend = addr_phase && hwrite;
        nxt_wr_idx  = addr_phase ? addr_idx : wr_idx_ff;
        // Ready rests low for one cycle after reset so no transfer meets half-cleared state
        nxt_ready   = 1'b1;
        // Every register access is legal, so the response never leaves OKAY
        nxt_resp    = 1'b0;
        nxt_hrdata  = 32'h0;
        if (addr_phase && !hwrite) begin
            unique case (addr_idx)
                IDX_CTRL0: begin
                    nxt_hrdata[B_READY]     = !busy;
                    nxt_hrdata[B_CPU_EN]    = cpu_en_ff;
                    nxt_hrdata[B_LOW_EN]    = low_en_ff;
                    nxt_hrdata[B_PROG_ERR]  = prog_err_ff;
                    nxt_hrdata[B_ERASE_ERR] = erase_err_ff;
                end
                IDX_CTRL1: begin
                    nxt_hrdata[B_SUBMODE] = submode_ff;
                    nxt_hrdata[B_LOCK0]   = lock0_ff;
                    nxt_hrdata[B_LOCK1]   = lock1_ff;
                end
                IDX_CTRL4: begin
                    nxt_hrdata[B_SUSP_EN]   = susp_en_ff;
                    nxt_hrdata[B_ERS_REQ]   = ers_req_ff;
                    nxt_hrdata[B_PRG_REQ]   = prg_req_ff;
                    nxt_hrdata[B_ERS_ACT]   = busy && is_erase_ff;
                    nxt_hrdata[B_PRG_ACT]   = busy && !is_erase_ff;
                    nxt_hrdata[B_RD_PERMIT] = rd_allow_ff;
                end
                IDX_CMD: begin
                    nxt_hrdata[B_STAT_MODE] = stat_mode_ff;
                end
                IDX_STATUS: begin
                    // Only meaningful in the RAM-executed sub-mode
                    if (!submode_ff) begin
                        nxt_hrdata[B_SR_READY] = !busy;
                        nxt_hrdata[B_SR_EFAIL] = erase_err_ff;
                        nxt_hrdata[B_SR_PFAIL] = prog_err_ff;
                    end
                end
                default: nxt_hrdata = 32'h0;
            endcase
        end
    end

    // Register, command and operation state
    always_comb begin
        nxt_state     = state_ff;
        nxt_lat_cnt   = lat_cnt_ff;
        nxt_cpu_en    = cpu_en_ff;
        nxt_low_en    = low_en_ff;
        nxt_submode   = submode_ff;
        nxt_lock0     = lock0_ff;
        nxt_lock1     = lock1_ff;
        nxt_susp_en   = susp_en_ff;
        nxt_ers_req   = ers_req_ff;
        nxt_prg_req   = prg_req_ff;
        nxt_is_erase  = is_erase_ff;
        nxt_block     = block_ff;
        nxt_prog_err  = prog_err_ff;
        nxt_erase_err = erase_err_ff;
        nxt_stat_mode = stat_mode_ff;
        start_ok      = 1'b0;
        finish        = 1'b0;
        susp_pending  = 1'b0;

        // One down-counter times both the post-command interrupt guard and the suspend wait
        if (lat_cnt_ff != 12'h0) begin
            nxt_lat_cnt = lat_cnt_ff - 12'h1;
        end

        if (wr_pend_ff) begin
            unique case (wr_idx_ff)
                IDX_CTRL0: begin
                    nxt_cpu_en = hwdata[B_CPU_EN];
                    nxt_low_en = hwdata[B_LOW_EN];
                    // Leaving rewrite mode also drops the flash-executed sub-mode and status mode
                    if (!hwdata[B_CPU_EN]) begin
                        nxt_submode   = 1'b0;
                        nxt_stat_mode = 1'b0;
                    end
                end
                IDX_CTRL1: begin
                    // A flash_control_1 write cannot change the sub-mode under a running operation
                    if (!busy) begin
                        nxt_submode = hwdata[B_SUBMODE] && cpu_en_ff;
                    end
                    nxt_lock0 = hwdata[B_LOCK0];
                    nxt_lock1 = hwdata[B_LOCK1];
                end
                IDX_CTRL4: begin
                    nxt_susp_en = hwdata[B_SUSP_EN];
                    // Requests count only with suspend enabled and a matching operation
                    nxt_ers_req = hwdata[B_ERS_REQ] && hwdata[B_SUSP_EN] && busy && is_erase_ff;
                    nxt_prg_req = hwdata[B_PRG_REQ] && hwdata[B_SUSP_EN] && busy && !is_erase_ff;
                end
                IDX_CMD: begin
                    if (hwdata[B_CMD_RDSTAT] && cpu_en_ff && !submode_ff) begin
                        nxt_stat_mode = 1'b1;
                    end else if (hwdata[B_CMD_RDARR]) begin
                        nxt_stat_mode = 1'b0;
                    end
                    // Commands need rewrite enable, an idle engine and an unlocked block
                    start_ok = cpu_en_ff && !busy && blk_ok &&
                               (hwdata[B_CMD_PROG] ^ hwdata[B_CMD_ERASE]);
                end
                default: begin
                end
            endcase
        end

        unique case (state_ff)
            ST_IDLE: begin
                // A refused command leaves the engine idle; software sees the ready flag stay 1
                if (start_ok) begin
                    nxt_state    = ST_RUN;
                    nxt_is_erase = hwdata[B_CMD_ERASE];
                    nxt_block    = cmd_block;
                    nxt_lat_cnt  = LAT_LOAD;
                end
            end
            ST_RUN: begin
                // Completion outranks a suspend request raised in the same cycle
                if (core_rsp.done) begin
                    finish = 1'b1;
                end else begin
                    // Hardware sets the request after the software write, so set wins
                    if (submode_ff && susp_en_ff && irq_request && lat_cnt_ff == 12'h0) begin
                        if (is_erase_ff) begin
                            nxt_ers_req = 1'b1;
                        end else begin
                            nxt_prg_req = 1'b1;
                        end
                    end
                    susp_pending = nxt_ers_req || nxt_prg_req;
                    if (susp_pending) begin
                        nxt_state   = ST_SUSP_WAIT;
                        nxt_lat_cnt = LAT_LOAD;
                    end
                end
            end
            ST_SUSP_WAIT: begin
                // The core may still finish before it honours the suspend
                if (core_rsp.done) begin
                    finish = 1'b1;
                end else if (!nxt_ers_req && !nxt_prg_req) begin
                    nxt_state = ST_RUN;
                end else if (lat_cnt_ff == 12'h0) begin
                    nxt_state = ST_SUSPENDED;
                end
            end
            ST_SUSPENDED: begin
                // Done cannot arrive here: the core makes no progress while suspended
                if (!nxt_ers_req && !nxt_prg_req) begin
                    nxt_state = ST_RUN;
                end
            end
        endcase

        // Request bits are cleared so the next operation starts unsuspended
        if (finish) begin
            nxt_state   = ST_IDLE;
            nxt_ers_req = 1'b0;
            nxt_prg_req = 1'b0;
            if (is_erase_ff) begin
                nxt_erase_err = core_rsp.fail;
            end else begin
                nxt_prog_err = core_rsp.fail;
            end
            nxt_stat_mode = !submode_ff;
        end
    end

    // Outputs follow the next state so they line up with it
    always_comb begin
        nxt_core_req.run     = (nxt_state != ST_IDLE);
        nxt_core_req.erase   = nxt_is_erase;
        nxt_core_req.block   = nxt_block;
        nxt_core_req.suspend = (nxt_state == ST_SUSP_WAIT) || (nxt_state == ST_SUSPENDED);
        // Read permit is withheld from the suspend request until the latency has run out
        nxt_rd_allow         = (nxt_state == ST_IDLE) || (nxt_state == ST_SUSPENDED);
        // CPU keeps running in RAM sub-mode; held until suspend in flash sub-mode
        nxt_cpu_hold         = nxt_submode && nxt_core_req.run && (nxt_state != ST_SUSPENDED);
        nxt_irq_allow        = !nxt_cpu_hold;
    end

    // Bus side registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= 9'h0;
            hrdata_ff    <= 32'h0;
            ready_ff     <= 1'b0;
            resp_ff      <= 1'b0;
        end else begin
            wr_pend_ff   <= nxt_wr_pend;
            wr_idx_ff    <= nxt_wr_idx;
            hrdata_ff    <= nxt_hrdata;
            ready_ff     <= nxt_ready;
            resp_ff      <= nxt_resp;
        end
    end

    // Register and operation state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff     <= ST_IDLE;
            lat_cnt_ff   <= 12'h0;
            cpu_en_ff    <= CTRL0_RESET[B_CPU_EN];
            low_en_ff    <= CTRL0_RESET[B_LOW_EN];
            submode_ff   <= CTRL1_RESET[B_SUBMODE];
            lock0_ff     <= CTRL1_RESET[B_LOCK0];
            lock1_ff     <= CTRL1_RESET[B_LOCK1];
            susp_en_ff   <= CTRL4_RESET[B_SUSP_EN];
            ers_req_ff   <= CTRL4_RESET[B_ERS_REQ];
            prg_req_ff   <= CTRL4_RESET[B_PRG_REQ];
            is_erase_ff  <= 1'b0;
            block_ff     <= 4'h0;
            prog_err_ff  <= CTRL0_RESET[B_PROG_ERR];
            erase_err_ff <= CTRL0_RESET[B_ERASE_ERR];
            stat_mode_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            lat_cnt_ff   <= nxt_lat_cnt;
            cpu_en_ff    <= nxt_cpu_en;
            low_en_ff    <= nxt_low_en;
            submode_ff   <= nxt_submode;
            lock0_ff     <= nxt_lock0;
            lock1_ff     <= nxt_lock1;
            susp_en_ff   <= nxt_susp_en;
            ers_req_ff   <= nxt_ers_req;
            prg_req_ff   <= nxt_prg_req;
            is_erase_ff  <= nxt_is_erase;
            block_ff     <= nxt_block;
            prog_err_ff  <= nxt_prog_err;
            erase_err_ff <= nxt_erase_err;
            stat_mode_ff <= nxt_stat_mode;
        end
    end

    // Hold and permit outputs change together with the state they come from
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_hold_ff  <= 1'b0;
            irq_allow_ff <= 1'b1;
            rd_allow_ff  <= CTRL4_RESET[B_RD_PERMIT];
            core_req_ff  <= '0;
        end else begin
            cpu_hold_ff  <= nxt_cpu_hold;
            irq_allow_ff <= nxt_irq_allow;
            rd_allow_ff  <= nxt_rd_allow;
            core_req_ff  <= nxt_core_req;
        end
    end

    // Zero-wait slave: every transfer completes OKAY in one data phase
    assign hrdata           = hrdata_ff;
    assign hreadyout        = ready_ff;
    assign hresp            = resp_ff;
    assign core_req         = core_req_ff;
    assign cpu_hold         = cpu_hold_ff;
    assign irq_ack_allow    = irq_allow_ff;
    assign flash_read_allow = rd_allow_ff;

endmodule // flash_rewrite_ctrl

/* File: common/flash_rewrite_pkg.sv */
// Constants and carriers for the CPU flash rewrite controller
package flash_rewrite_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [8:0] IDX_CTRL0   = 9'h1b7;
    localparam logic [8:0] IDX_CTRL1   = 9'h1b5;
    localparam logic [8:0] IDX_CTRL4   = 9'h1b3;
    localparam logic [8:0] IDX_CMD     = 9'h1c0;
    localparam logic [8:0] IDX_STATUS  = 9'h1c1;

    // flash_control_0 fields
    localparam int B_READY      = 0;
    localparam int B_CPU_EN     = 1;
    localparam int B_LOW_EN     = 2;
    localparam int B_PROG_ERR   = 6;
    localparam int B_ERASE_ERR  = 7;
    localparam logic [7:0] CTRL0_RESET = 8'h01;

    // flash_control_1 fields
    localparam int B_SUBMODE    = 1;
    localparam int B_LOCK0      = 5;
    localparam int B_LOCK1      = 6;
    localparam logic [7:0] CTRL1_RESET = 8'h60;

    // flash_control_4 fields
    localparam int B_SUSP_EN    = 0;
    localparam int B_ERS_REQ    = 1;
    localparam int B_PRG_REQ    = 2;
    localparam int B_ERS_ACT    = 3;
    localparam int B_PRG_ACT    = 4;
    localparam int B_RD_PERMIT  = 6;
    localparam logic [7:0] CTRL4_RESET = 8'h40;

    // Command register fields
    localparam int B_CMD_PROG   = 0;
    localparam int B_CMD_ERASE  = 1;
    localparam int B_CMD_BLK_LO = 4;
    localparam int B_CMD_RDSTAT = 8;
    localparam int B_CMD_RDARR  = 9;
    localparam int B_STAT_MODE  = 8;

    // Status register fields
    localparam int B_SR_READY   = 7;
    localparam int B_SR_EFAIL   = 5;
    localparam int B_SR_PFAIL   = 4;

    // Suspend latency
    localparam int CLK_PERIOD_NS       = 10;
    localparam int SUSPEND_LATENCY_NS  = 5000;
    localparam int SUSPEND_LATENCY_CYC = (SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] LAT_LOAD   = 12'(SUSPEND_LATENCY_CYC);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_SUSP_WAIT,
        ST_SUSPENDED
    } op_state_e;

    // Request to the flash array core
    typedef struct packed {
        logic       run;
        logic       erase;
        logic       suspend;
        logic [3:0] block;
    } core_req_s;

    // Answer from the flash array core
    typedef struct packed {
        logic done;
        logic fail;
    } core_rsp_s;

endpackage

/* File: verif/flash_core_model.sv */
// Behavioural flash array core answering the rewrite controller
`timescale 1ns/10ps
module flash_core_model #(
    parameter int OP_CYC = 800
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // Controller side
    input  wire flash_rewrite_pkg::core_req_s core_req,
    output flash_rewrite_pkg::core_rsp_s      core_rsp,
    // Scenario control
    input  wire logic                         fail_sel
);
    import flash_rewrite_pkg::*;
    logic [15:0] cnt_ff;
    logic        done_ff;
    // Work advances only while running and not suspended, so a suspend really pauses it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= 16'h0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!core_req.run) begin
                cnt_ff <= 16'h0;
            end else if (!core_req.suspend && cnt_ff != 16'(OP_CYC)) begin
                cnt_ff  <= cnt_ff + 16'h1;
                done_ff <= (cnt_ff == 16'(OP_CYC - 1));
            end
        end
    end
    // Fail means nothing without done, so it wanders otherwise
    assign core_rsp.done = done_ff;
    assign core_rsp.fail = done_ff ? fail_sel : cnt_ff[0];
endmodule // flash_core_model

/* File: verif/flash_rewrite_monitor.sv */
// Port assertions for the flash rewrite controller
`timescale 1ns/10ps
module flash_rewrite_monitor (
    // Clock and reset
    input wire logic                         sys_clk,
    input wire logic                         rst,
    // Observed ports
    input wire logic                         hreadyout,
    input wire flash_rewrite_pkg::core_req_s core_req,
    input wire flash_rewrite_pkg::core_rsp_s core_rsp,
    input wire logic                         irq_request,
    input wire logic                         cpu_hold,
    input wire logic                         irq_ack_allow,
    input wire logic                         flash_read_allow
);
    import flash_rewrite_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic busy;
    assign busy = core_req.run && !core_req.suspend;

    bus_ready_a: assert property (!$past(rst) |-> hreadyout)
        else $error("bus stalled");
    ack_mirror_a: assert property (irq_ack_allow == !cpu_hold)
        else $error("ack allow not inverse of hold");
    busy_no_read_a: assert property (busy && $past(busy) |-> !flash_read_allow)
        else $error("read allowed while operation runs");
    idle_read_a: assert property (!core_req.run && !$past(core_req.run) |-> flash_read_allow)
        else $error("read blocked while idle");
    hold_run_a: assert property (cpu_hold |-> core_req.run || $past(core_req.run))
        else $error("cpu held without operation");
    early_read_a: assert property ($rose(core_req.suspend) |-> (!flash_read_allow || !core_req.run) [*8])
        else $error("read allowed before suspend latency");
    read_bound_a: assert property ($rose(core_req.suspend) |-> ##[1:520] (flash_read_allow || !core_req.suspend))
        else $error("suspend never permitted reads");
    done_idle_a: assert property (core_rsp.done && busy |=> !core_req.run)
        else $error("operation not ended by done");
    irq_susp_a: assert property ($rose(core_req.suspend) && cpu_hold |-> $past(irq_request))
        else $error("held suspend without interrupt");
    hold_release_a: assert property (core_req.suspend && cpu_hold |-> ##[1:520] (!cpu_hold || !core_req.suspend))
        else $error("cpu not released by suspend");
endmodule // flash_rewrite_monitor

bind flash_rewrite_ctrl flash_rewrite_monitor u_monitor (
    .sys_clk(sys_clk), .rst(rst), .hreadyout(hreadyout), .core_req(core_req), .core_rsp(core_rsp),
    .irq_request(irq_request), .cpu_hold(cpu_hold), .irq_ack_allow(irq_ack_allow),
    .flash_read_allow(flash_read_allow));

/* File: verif/flash_rewrite_ctrl_tb_top.sv */
// Self-checking bench for the flash rewrite controller
`timescale 1ns/10ps
module flash_rewrite_ctrl_tb_top;
    import flash_rewrite_pkg::*;
    logic        sys_clk, rst, hsel, hwrite, hready, irq_request, fail_sel;
    logic        hreadyout, hresp, cpu_hold, irq_ack_allow, flash_read_allow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    core_req_s   core_req;
    core_rsp_s   core_rsp;
    int          n_errors, checks, seed, n, t0, cyc, blk, perr, eerr;

    assign hready = hreadyout;
    flash_rewrite_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_req(core_req), .core_rsp(core_rsp),
        .irq_request(irq_request), .cpu_hold(cpu_hold), .irq_ack_allow(irq_ack_allow),
        .flash_read_allow(flash_read_allow));
    flash_core_model #(.OP_CYC(800)) u_core (.sys_clk(sys_clk), .rst(rst), .core_req(core_req),
        .core_rsp(core_rsp), .fail_sel(fail_sel));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic give_verdict();
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Address phase held until ready, then data phase held until ready
    task automatic xfer(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {21'h0, idx, 2'b00};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [8:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rdchk(input string name, input logic [8:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(name, rd, exp);
    endtask

    task automatic wait_idle();
        n = 0;
        while (core_req.run !== 1'b0 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("idle", core_req.run, 0);
    endtask

    // Expected control word 0 with rewrite enabled and low blocks disabled
    function automatic logic [31:0] c0(input logic rdy);
        return {24'h0, eerr[0], perr[0], 4'h0, 1'b1, rdy};
    endfunction

    initial begin
        sys_clk = 0; rst = 1; hsel = 1; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0;
        hsize = 3'b010; irq_request = 0; fail_sel = 0; cyc = 0; seed = 32'h7945;
        n_errors = 0; checks = 0; perr = 0; eerr = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk("ctrl0", IDX_CTRL0, 32'h01);
        rdchk("ctrl1", IDX_CTRL1, 32'h60);
        rdchk("ctrl4", IDX_CTRL4, 32'h40);
        rdchk("unmapped", 9'h000, 32'h0);
        wr(IDX_CMD, 32'h22);
        @(posedge sys_clk);
        chk("run off", core_req.run, 0);
        wr(IDX_CTRL1, 32'h62);
        rdchk("sub early", IDX_CTRL1, 32'h60);
        // Every low-block enable and lock pairing on blocks 0 and 1
        for (int k = 0; k < 16; k++) begin
            wr(IDX_CTRL0, {29'h0, k[0], 2'b10});
            wr(IDX_CTRL1, {25'h0, k[2], k[1], 5'h0});
            wr(IDX_CMD, {27'h0, k[3], 4'h2});
            @(posedge sys_clk);
            chk("lock gate", core_req.run, k[0] && !(k[3] ? k[2] : k[1]));
            wait_idle();
        end
        wr(IDX_CTRL0, 32'h02);
        wr(IDX_CTRL1, 32'h60);
        // Software suspend of erase then program; code runs outside flash here
        for (int op = 0; op < 2; op++) begin
            blk = 2 + ({$random(seed)} % 14);
            fail_sel <= $random(seed);
            wr(IDX_CMD, (blk << 4) | (op ? 1 : 2));
            wr(IDX_CTRL4, op ? 32'h05 : 32'h03);
            chk("target", {core_req.erase, core_req.block}, {!op[0], blk[3:0]});
            t0 = cyc;
            n = 0;
            while (flash_read_allow !== 1'b1 && n < 700) begin
                @(posedge sys_clk);
                n++;
            end
            chk("susp latency", cyc - t0 >= 500 && n < 700, 1);
            rdchk("ctrl4 susp", IDX_CTRL4, op ? 32'h55 : 32'h4b);
            rdchk("busy", IDX_CTRL0, c0(0));
            wr(IDX_CTRL4, 32'h01);
            wait_idle();
            if (op) perr = fail_sel;
            else eerr = fail_sel;
            rdchk("flags", IDX_CTRL0, c0(1));
            xfer(1'b0, IDX_STATUS, 32'h0);
            chk("status", rd & (op ? 32'h90 : 32'ha0), 32'h80 | (fail_sel << (op ? 4 : 5)));
            rdchk("stat mode", IDX_CMD, 32'h100);
        end
        wr(IDX_CMD, 32'h200);
        rdchk("array cmd", IDX_CMD, 32'h0);
        wr(IDX_CMD, 32'h100);
        rdchk("stat cmd", IDX_CMD, 32'h100);
        wr(IDX_CMD, 32'h32);
        wr(IDX_CTRL4, 32'h02);
        repeat (3) @(posedge sys_clk);
        chk("no suspend", core_req.suspend, 0);
        wait_idle();
        eerr = fail_sel;
        wr(IDX_CTRL1, 32'h62);
        rdchk("submode", IDX_CTRL1, 32'h62);
        wr(IDX_CTRL4, 32'h01);
        // Interrupt raised at once must wait for the latency before it suspends
        for (int op = 0; op < 2; op++) begin
            fail_sel <= $random(seed);
            wr(IDX_CMD, op ? 32'h51 : 32'h52);
            irq_request <= 1'b1;
            @(posedge sys_clk);
            chk("held", cpu_hold, 1);
            chk("ack held", irq_ack_allow, 0);
            chk("target fl", {core_req.erase, core_req.block}, {!op[0], 4'h5});
            t0 = cyc;
            n = 0;
            while (cpu_hold !== 1'b0 && n < 1500) begin
                @(posedge sys_clk);
                n++;
            end
            chk("irq late", cyc - t0 >= 999 && n < 1500, 1);
            chk("ack free", irq_ack_allow, 1);
            rdchk("auto req", IDX_CTRL4, op ? 32'h55 : 32'h4b);
            irq_request <= 1'b0;
            rdchk("busy fl", IDX_CTRL0, c0(0));
            wr(IDX_CTRL4, 32'h01);
            wait_idle();
            if (op) perr = fail_sel;
            else eerr = fail_sel;
            rdchk("flags fl", IDX_CTRL0, c0(1));
            rdchk("array mode", IDX_CMD, 32'h0);
        end
        chk("okay", hresp, 0);
        give_verdict();
    end

    // Whole run is about ten thousand cycles
    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end
endmodule // flash_rewrite_ctrl_tb_top
